// file: pkg/meter_pkg.sv
/*
  Shared constants for the panel-meter control block: timing, count scaling,
  register map, interrupt layout and sequencer states.
  Assumes a 200 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package meter_pkg;

  // Clock and phase timing
  localparam int unsigned CLK_KHZ      = 200000;
  localparam int unsigned REF_WAIT_MS  = 6000;
  localparam int unsigned CAL_MS       = 2000;
  localparam int unsigned HOLD_CAL_MS  = 2000;
  localparam int unsigned REF_WAIT_CYC = REF_WAIT_MS * CLK_KHZ;
  localparam int unsigned CAL_CYC      = CAL_MS * CLK_KHZ;
  localparam int unsigned HOLD_CAL_CYC = HOLD_CAL_MS * CLK_KHZ + 1;
  localparam int unsigned POR_CYC      = 16;

  // Count scaling: 1.024 * 20000 and 1.024 * 2000 are exact integers
  localparam int          RATIO_W      = 24;
  localparam int          RATIO_FRAC   = 23;
  localparam int          WIDE_W       = 24;
  localparam int          DISP_W       = 16;
  localparam int          SCALE_4P5    = 20480;
  localparam int          SCALE_3P5    = 2048;
  localparam int          NARROW_MULT  = 10;
  localparam int          NEG_ADJUST   = 1;
  localparam int          FULL_4P5     = 19999;
  localparam int          FULL_3P5     = 1999;
  localparam logic signed [DISP_W-1:0] SHOW_OVER  = 16'sh0001;
  localparam logic signed [DISP_W-1:0] SHOW_UNDER = 16'shffff;

  // Register byte offsets
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_COUNT    = 8'h08;
  localparam logic [7:0]  REG_PEAK     = 8'h0c;
  localparam logic [7:0]  REG_IRQSTAT  = 8'h10;
  localparam logic [7:0]  REG_IRQMASK  = 8'h14;

  // Field positions
  localparam int          CTRL_CAL_BIT = 0;
  localparam int          IRQ_RESULT   = 0;
  localparam int          IRQ_OVER     = 1;
  localparam int          IRQ_UNDER    = 2;
  localparam int          IRQ_CALDONE  = 3;
  localparam int          IRQ_W        = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // Strap synchroniser lanes
  localparam int          STRAP_FREEZE = 0;
  localparam int          STRAP_PEAK   = 1;
  localparam int          STRAP_SPAN   = 2;
  localparam int          STRAP_REFSEL = 3;
  localparam int          STRAP_W      = 4;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    SEQ_POR     = 2'b00,
    SEQ_REFWAIT = 2'b01,
    SEQ_CAL     = 2'b10,
    SEQ_RUN     = 2'b11
  } seq_e;

endpackage

// file: verilog/phase_timer.sv
/*
  One-shot cycle timer: counts a given number of cycles after a start pulse
  and then gives a one-cycle done pulse.
  Assumes start and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
module phase_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         resetn,
  // Control
  input  wire logic         start,
  input  wire logic         clear,
  input  wire logic [W-1:0] limit,
  // Status
  output logic              busy,
  output logic              done
);

  logic [W-1:0] count_r, count_nxt;
  logic         busy_r, busy_nxt;
  logic         done_r, done_nxt;

  always_comb begin
    count_nxt = count_r;
    busy_nxt  = busy_r;
    done_nxt  = 1'b0;
    if (clear) begin
      busy_nxt  = 1'b0;
      count_nxt = '0;
    end else if (start) begin
      busy_nxt  = 1'b1;
      count_nxt = '0;
    end else if (busy_r) begin
      if (count_r >= limit - 1'b1) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        count_nxt = count_r + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_r <= '0;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      busy_r  <= busy_nxt;
      done_r  <= done_nxt;
    end
  end

  assign busy = busy_r;
  assign done = done_r;

endmodule

// file: verilog/meter_result_display_control.sv
/*
  Control logic of a panel-meter converter: power-up sequence, offset
  calibration control, count scaling, peak/hold selection and range display.
  Assumes the filter delivers a signed input/reference ratio with a one-cycle
  valid pulse, and an AHB-Lite master with this block as its only slave.
*/
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
// Functional notes
// - Above positive full scale show lone 1; below negative full scale show -1.
// - At power-up hold decimation filter and modulator in reset before conversions.
// - 4.5-digit part waits 6 s for reference, then enters enhanced calibration.
// - During that wait, show the reference reading once it is stable.
// - Enhanced calibration lasts 2 s; conversions start only afterwards.
// - Ordinary offset calibration runs every conversion cycle, unrequested.
// - Freeze held high over 2 s requests enhanced calibration on that variant.
// - Maxima tracking high displays only the highest value seen.
// - Peak mode: show first result, then update only on a larger result.
// - Maxima tracking low clears stored peak and stops tracking.
// - Freeze high keeps the displayed reading unchanged.
// - Wide span, 4.5 digits: count is 1.024 times ratio times 20000.
// - 3.5-digit variant uses scale 2000 in the same formula.
// - Negative input difference adds one count to the scaled result.
// - Narrow span multiplies the count by 10 before negative adjustment.
// - Reference select low chooses the external differential reference.
// - Display priority: freeze, then peak, then latest result.
`timescale 1ns/1ps
module meter_result_display_control
  import meter_pkg::*;
#(
  parameter bit          FOUR_HALF_DIGIT = 1'b1,
  parameter bit          ON_DEMAND_CAL   = 1'b1,
  parameter int unsigned REF_WAIT_CYCLES = REF_WAIT_CYC,
  parameter int unsigned CAL_CYCLES      = CAL_CYC,
  parameter int unsigned HOLD_CAL_CYCLES = HOLD_CAL_CYC
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  // Strap inputs
  input  wire logic                      freezeIn,
  input  wire logic                      peakTrackIn,
  input  wire logic                      spanNarrowIn,
  input  wire logic                      reference_source_select,
  // Converter side
  input  wire logic                      refStable,
  input  wire logic                      resultValid,
  input  wire logic signed [RATIO_W-1:0] ratioIn,
  output logic                           filterReset,
  output logic                           modReset,
  output logic                           useExtRef,
  output logic                           enhancedCal,
  output logic                           offsetCal,
  // Display side
  output logic signed [DISP_W-1:0]       dispCount,
  output logic                           showOver,
  output logic                           showUnder,
  // Interrupt
  output logic                           irq
);

  localparam int SCALE = FOUR_HALF_DIGIT ? SCALE_4P5 : SCALE_3P5;
  localparam int FULL  = FOUR_HALF_DIGIT ? FULL_4P5 : FULL_3P5;

  function automatic logic signed [WIDE_W-1:0] scaleCount(
    input logic signed [RATIO_W-1:0] ratio,
    input logic                      narrow
  );
    logic signed [47:0] prod;
    prod = 48'(ratio) * 48'(SCALE);
    prod = prod >>> RATIO_FRAC;
    if (narrow)
      prod = prod * 48'(NARROW_MULT);
    if (ratio < 0)
      prod = prod + 48'(NEG_ADJUST);
    return prod[WIDE_W-1:0];
  endfunction

  // Strap synchroniser
  logic [STRAP_W-1:0] strapMeta_r, strapSync_r;
  logic freezeS, peakS, spanS;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strapMeta_r <= '0;
      strapSync_r <= '0;
    end else begin
      strapMeta_r <= {reference_source_select, spanNarrowIn, peakTrackIn, freezeIn};
      strapSync_r <= strapMeta_r;
    end
  end
  assign freezeS = strapSync_r[STRAP_FREEZE];
  assign peakS   = strapSync_r[STRAP_PEAK];
  assign spanS   = strapSync_r[STRAP_SPAN];

  // Bus address phase capture and register writes
  logic             wrPend_r, wrPend_nxt;
  logic             rdPend_r, rdPend_nxt;
  logic [7:0]       addr_r, addr_nxt;
  logic [31:0]      hrdata_r, hrdata_nxt;
  logic             calReq_r, calReq_nxt;
  logic [IRQ_W-1:0] irqMask_r, irqMask_nxt;
  logic             takeReq;
  logic [IRQ_W-1:0] irqClr;
  assign takeReq = hsel && hready && (htrans == HTRANS_NONSEQ);

  // Sequencer
  seq_e seq_r, seq_nxt;
  logic [4:0] porCnt_r, porCnt_nxt;
  logic       filterReset_r, filterReset_nxt, modReset_r, modReset_nxt;
  logic       enhancedCal_r, enhancedCal_nxt, offsetCal_r, offsetCal_nxt;
  logic       useExtRef_r, useExtRef_nxt;
  logic       refStart, refDone, calStart, calDone, holdDone, holdBusy;
  logic       freezeD_r, freezeD_nxt;
  logic       holdReq;

  // Display state
  logic signed [WIDE_W-1:0] latest_r, latest_nxt, peak_r, peak_nxt;
  logic signed [WIDE_W-1:0] held_r, held_nxt, shown, scaled;
  logic                     peakValid_r, peakValid_nxt;
  logic signed [DISP_W-1:0] dispCount_r, dispCount_nxt;
  logic                     showOver_r, showOver_nxt, showUnder_r, showUnder_nxt;
  logic                     takeResult;

  // Interrupts
  logic [IRQ_W-1:0] irqStat_r, irqStat_nxt, irqEvt;
  logic             irq_r, irq_nxt;

  assign scaled     = scaleCount(ratioIn, spanS);
  assign takeResult = resultValid &&
                      (seq_r == SEQ_RUN || (seq_r == SEQ_REFWAIT && refStable));

  always_comb begin
    wrPend_nxt  = takeReq && hwrite;
    rdPend_nxt  = takeReq && !hwrite;
    addr_nxt    = takeReq ? haddr[7:0] : addr_r;
    irqMask_nxt = irqMask_r;
    calReq_nxt  = 1'b0;
    irqClr      = '0;
    if (wrPend_r) begin
      case (addr_r)
        REG_CTRL:    calReq_nxt  = hwdata[CTRL_CAL_BIT];
        REG_IRQSTAT: irqClr      = hwdata[IRQ_W-1:0];
        REG_IRQMASK: irqMask_nxt = hwdata[IRQ_W-1:0];
        default:     irqClr      = '0;
      endcase
    end
    hrdata_nxt = '0;
    if (takeReq && !hwrite) begin
      case (haddr[7:0])
        REG_STATUS:  hrdata_nxt = {25'h0, useExtRef_r, holdBusy, peakValid_r,
                                   showUnder_r, showOver_r, seq_r};
        REG_COUNT:   hrdata_nxt = 32'(dispCount_r);
        REG_PEAK:    hrdata_nxt = 32'(peak_r);
        REG_IRQSTAT: hrdata_nxt = 32'(irqStat_r);
        REG_IRQMASK: hrdata_nxt = 32'(irqMask_r);
        default:     hrdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wrPend_r  <= 1'b0;
      rdPend_r  <= 1'b0;
      addr_r    <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
      calReq_r  <= 1'b0;
      irqMask_r <= IRQ_MASK_RST;
    end else begin
      wrPend_r  <= wrPend_nxt;
      rdPend_r  <= rdPend_nxt;
      addr_r    <= addr_nxt;
      hrdata_r  <= hrdata_nxt;
      calReq_r  <= calReq_nxt;
      irqMask_r <= irqMask_nxt;
    end
  end

  // Freeze held long enough asks for enhanced calibration
  assign holdReq = ON_DEMAND_CAL && holdDone && freezeS;

  phase_timer #(.W(32)) u_seqTimer (
    .mclk   (mclk),
    .resetn (resetn),
    .start  (refStart || calStart),
    .clear  (1'b0),
    // Limit is read every cycle, so it must stay put for the whole phase
    .limit  (calStart || seq_r == SEQ_CAL ? CAL_CYCLES : REF_WAIT_CYCLES),
    .busy   (),
    .done   (refDone)
  );
  assign calDone = refDone && seq_r == SEQ_CAL;

  phase_timer #(.W(32)) u_holdTimer (
    .mclk   (mclk),
    .resetn (resetn),
    .start  (freezeS && !freezeD_r),
    .clear  (!freezeS),
    .limit  (HOLD_CAL_CYCLES),
    .busy   (holdBusy),
    .done   (holdDone)
  );

  always_comb begin
    seq_nxt         = seq_r;
    porCnt_nxt      = porCnt_r;
    refStart        = 1'b0;
    calStart        = 1'b0;
    freezeD_nxt     = freezeS;
    useExtRef_nxt   = !strapSync_r[STRAP_REFSEL];
    offsetCal_nxt   = resultValid && seq_r == SEQ_RUN;
    case (seq_r)
      SEQ_POR: begin
        porCnt_nxt = porCnt_r + 5'd1;
        if (porCnt_r == 5'(POR_CYC - 1)) begin
          seq_nxt  = FOUR_HALF_DIGIT ? SEQ_REFWAIT : SEQ_CAL;
          refStart = FOUR_HALF_DIGIT;
          calStart = !FOUR_HALF_DIGIT;
        end
      end
      SEQ_REFWAIT: begin
        // Full wait kept even with a stable reference so it can settle
        if (refDone) begin
          seq_nxt  = SEQ_CAL;
          calStart = 1'b1;
        end
      end
      SEQ_CAL: begin
        if (refDone)
          seq_nxt = SEQ_RUN;
      end
      SEQ_RUN: begin
        if (holdReq || calReq_r) begin
          seq_nxt  = SEQ_CAL;
          calStart = 1'b1;
        end
      end
      default: seq_nxt = SEQ_POR;
    endcase
    filterReset_nxt = seq_nxt == SEQ_POR;
    modReset_nxt    = seq_nxt == SEQ_POR;
    enhancedCal_nxt = seq_nxt == SEQ_CAL;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      seq_r         <= SEQ_POR;
      porCnt_r      <= 5'd0;
      freezeD_r     <= 1'b0;
      filterReset_r <= 1'b1;
      modReset_r    <= 1'b1;
      enhancedCal_r <= 1'b0;
      offsetCal_r   <= 1'b0;
      useExtRef_r   <= 1'b0;
    end else begin
      seq_r         <= seq_nxt;
      porCnt_r      <= porCnt_nxt;
      freezeD_r     <= freezeD_nxt;
      filterReset_r <= filterReset_nxt;
      modReset_r    <= modReset_nxt;
      enhancedCal_r <= enhancedCal_nxt;
      offsetCal_r   <= offsetCal_nxt;
      useExtRef_r   <= useExtRef_nxt;
    end
  end

  // Value selection
  always_comb begin
    latest_nxt    = takeResult ? scaled : latest_r;
    peak_nxt      = peak_r;
    peakValid_nxt = peakValid_r;
    if (!peakS) begin
      peak_nxt      = '0;
      peakValid_nxt = 1'b0;
    end else if (takeResult && (!peakValid_r || scaled > peak_r)) begin
      peak_nxt      = scaled;
      peakValid_nxt = 1'b1;
    end
    if (freezeS)
      shown = held_r;
    else if (peakS)
      shown = peakValid_r ? peak_r : latest_r;
    else
      shown = latest_r;
    held_nxt      = shown;
    showOver_nxt  = shown > WIDE_W'(FULL);
    showUnder_nxt = shown < -WIDE_W'(FULL);
    if (showOver_nxt)
      dispCount_nxt = SHOW_OVER;
    else if (showUnder_nxt)
      dispCount_nxt = SHOW_UNDER;
    else
      dispCount_nxt = shown[DISP_W-1:0];
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      latest_r    <= '0;
      peak_r      <= '0;
      peakValid_r <= 1'b0;
      held_r      <= '0;
      dispCount_r <= '0;
      showOver_r  <= 1'b0;
      showUnder_r <= 1'b0;
    end else begin
      latest_r    <= latest_nxt;
      peak_r      <= peak_nxt;
      peakValid_r <= peakValid_nxt;
      held_r      <= held_nxt;
      dispCount_r <= dispCount_nxt;
      showOver_r  <= showOver_nxt;
      showUnder_r <= showUnder_nxt;
    end
  end

  // Interrupt status; a new event beats a clear in the same cycle
  always_comb begin
    irqEvt              = '0;
    irqEvt[IRQ_RESULT]  = takeResult;
    irqEvt[IRQ_OVER]    = showOver_nxt && !showOver_r;
    irqEvt[IRQ_UNDER]   = showUnder_nxt && !showUnder_r;
    irqEvt[IRQ_CALDONE] = calDone;
    irqStat_nxt         = (irqStat_r & ~irqClr) | irqEvt;
    irq_nxt             = |(irqStat_nxt & irqMask_nxt);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irqStat_r <= '0;
      irq_r     <= 1'b0;
    end else begin
      irqStat_r <= irqStat_nxt;
      irq_r     <= irq_nxt;
    end
  end

  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign hrdata      = hrdata_r;
  assign filterReset = filterReset_r;
  assign modReset    = modReset_r;
  assign useExtRef   = useExtRef_r;
  assign enhancedCal = enhancedCal_r;
  assign offsetCal   = offsetCal_r;
  assign dispCount   = dispCount_r;
  assign showOver    = showOver_r;
  assign showUnder   = showUnder_r;
  assign irq         = irq_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence freezeSteady;
    freezeS [*2];
  endsequence
  sequence calEntry;
    seq_r == SEQ_REFWAIT && refDone;
  endsequence

  a_por_reset_held: assert property (seq_r == SEQ_POR |-> filterReset_r && modReset_r)
    else $error("filter or modulator left reset during power-up");
  a_range_over: assert property (showOver_r |-> dispCount_r == SHOW_OVER && !showUnder_r)
    else $error("overrange shown with a wrong count");
  a_range_under: assert property (showUnder_r |-> dispCount_r == SHOW_UNDER)
    else $error("underrange shown with a wrong count");
  a_wait_then_cal: assert property (calEntry |=> seq_r == SEQ_CAL ##1 enhancedCal_r)
    else $error("reference wait did not lead to calibration");
  a_run_after_cal: assert property ($rose(seq_r == SEQ_RUN) |-> $past(seq_r) == SEQ_CAL)
    else $error("conversions started without calibration");
  a_offset_each: assert property (resultValid && seq_r == SEQ_RUN |=> offsetCal_r)
    else $error("conversion without offset calibration");
  a_peak_grows: assert property (peakS && $past(peakS) && $past(peakValid_r)
                                 |-> peak_r >= $past(peak_r))
    else $error("stored peak decreased");
  a_peak_cleared: assert property (!peakS |=> !peakValid_r && peak_r == 0)
    else $error("peak not cleared");
  a_hold_steady: assert property (freezeSteady |=> $stable(dispCount_r))
    else $error("display changed while frozen");
  a_demand_cal: assert property (seq_r == SEQ_RUN && holdReq |=> seq_r == SEQ_CAL)
    else $error("long freeze did not start calibration");
  a_read_data_idle: assert property (!rdPend_r |-> hrdata_r == '0)
    else $error("read data left on the bus outside a data phase");

endmodule

// file: bench/led_display_model.sv
/*
  Display-side stand-in: latches the count the block presents to the
  digit drivers and counts how often the shown value changes.
  Assumes the block drives dispCount from mclk registers.
*/
`timescale 1ns/1ps
module led_display_model
  import meter_pkg::*;
(
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  // Digit data from the block
  input  wire logic signed [DISP_W-1:0] dispCount,
  // Observation
  output logic signed [DISP_W-1:0]      litValue,
  output int                            changes
);
  // Counting changes shows whether a held reading really stood still
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      litValue <= '0;
      changes  <= 0;
    end else if (dispCount !== litValue) begin
      litValue <= dispCount;
      changes  <= changes + 1;
    end
  end
endmodule

// file: bench/meter_result_display_control_tb_top.sv
/*
  Self-checking bench for the panel-meter control block.
  Assumes shortened phase counts (50/30/40 cycles) and a 200 MHz clock.
*/
`timescale 1ns/1ps
module meter_result_display_control_tb_top
  import meter_pkg::*;
;
  logic                     mclk, resetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]              haddr, hwdata, hrdata, d;
  logic [1:0]               htrans;
  logic [2:0]               hsize;
  logic                     freezeIn, peakTrackIn, spanNarrowIn, refSel, refStable;
  logic                     resultValid, filterReset, modReset, useExtRef;
  logic                     enhancedCal, offsetCal, showOver, showUnder, irq;
  logic signed [RATIO_W-1:0] ratioIn;
  logic signed [DISP_W-1:0] dispCount, litValue, dispCount3;
  int                       changes, errorCnt, nChecks, cycles, sinceRst, n, c0;
  logic signed [15:0]       held;

  assign hready = hreadyout;

  meter_result_display_control #(.REF_WAIT_CYCLES(50), .CAL_CYCLES(30),
    .HOLD_CAL_CYCLES(40)) u_meter_result_display_control (
    .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .freezeIn(freezeIn),
    .peakTrackIn(peakTrackIn), .spanNarrowIn(spanNarrowIn),
    .reference_source_select(refSel), .refStable(refStable),
    .resultValid(resultValid), .ratioIn(ratioIn), .filterReset(filterReset),
    .modReset(modReset), .useExtRef(useExtRef), .enhancedCal(enhancedCal),
    .offsetCal(offsetCal), .dispCount(dispCount), .showOver(showOver),
    .showUnder(showUnder), .irq(irq));

  // 3.5-digit variant on the same stimulus, checked for its count only
  meter_result_display_control #(.FOUR_HALF_DIGIT(1'b0), .REF_WAIT_CYCLES(50),
    .CAL_CYCLES(30), .HOLD_CAL_CYCLES(40)) u_meter_result_display_control_3p5 (
    .mclk(mclk), .resetn(resetn), .hsel(1'b0), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(), .hresp(), .hrdata(), .freezeIn(freezeIn),
    .peakTrackIn(peakTrackIn), .spanNarrowIn(spanNarrowIn),
    .reference_source_select(refSel), .refStable(refStable),
    .resultValid(resultValid), .ratioIn(ratioIn), .filterReset(), .modReset(),
    .useExtRef(), .enhancedCal(), .offsetCal(), .dispCount(dispCount3),
    .showOver(), .showUnder(), .irq());

  led_display_model u_led_display_model (.mclk(mclk), .resetn(resetn),
    .dispCount(dispCount), .litValue(litValue), .changes(changes));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Hang guard: the whole sequence needs well under 2000 cycles
  always @(posedge mclk) begin
    cycles   <= cycles + 1;
    sinceRst <= resetn ? sinceRst + 1 : 0;
    if (cycles == 20000) begin
      errorCnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic ahbXfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                         output logic [31:0] rd);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  function automatic logic signed [15:0] expCount(input logic signed [23:0] r,
                                                  input bit nar, input bit big = 1'b1);
    longint e;
    e = (longint'(r) * (big ? SCALE_4P5 : SCALE_3P5)) >>> RATIO_FRAC;
    if (nar) e = e * NARROW_MULT;
    if (r < 0) e = e + NEG_ADJUST;
    if (e > (big ? FULL_4P5 : FULL_3P5)) return SHOW_OVER;
    if (e < -(big ? FULL_4P5 : FULL_3P5)) return SHOW_UNDER;
    return e[15:0];
  endfunction

  task automatic sendRes(input logic signed [23:0] r, input bit run);
    @(posedge mclk);
    resultValid <= 1'b1;
    ratioIn     <= r;
    @(posedge mclk);
    resultValid <= 1'b0;
    #1;
    chk("offsetCal", run, offsetCal);
    @(posedge mclk);
    #1;
  endtask

  task automatic waitCal(input logic lvl, output int k);
    k = 0;
    while (enhancedCal !== lvl && k < 200) begin
      @(posedge mclk);
      #1;
      k++;
    end
  endtask

  task automatic t_powerup();
    chk("filterReset", 1, filterReset);
    chk("modReset", 1, modReset);
    ahbXfer(REG_STATUS, 1'b0, 32'h0, d);
    chk("seqPor", 0, d[1:0]);
    repeat (18) @(posedge mclk);
    refStable <= 1'b1;
    sendRes(24'sh4ccccc, 1'b0);
    chk("refReading", expCount(24'sh4ccccc, 1'b0), dispCount);
    waitCal(1'b1, n);
    chk("calStart", 1, sinceRst >= 64 && sinceRst <= 70);
    waitCal(1'b0, n);
    chk("calLength", 1, n >= 29 && n <= 31);
    ahbXfer(REG_STATUS, 1'b0, 32'h0, d);
    chk("seqRun", 3, d[1:0]);
    chk("filterRun", 0, filterReset);
    chk("modRun", 0, modReset);
    chk("hresp", 0, hresp);
    $display("test powerup done");
  endtask

  task automatic t_scale();
    logic signed [23:0] rt[6];
    logic signed [15:0] e;
    rt = '{24'sh000800, -24'sh000800, 24'sh080000, -24'sh080000, 24'sh200000,
           -24'sh200000};
    for (int nar = 0; nar < 2; nar++) begin
      spanNarrowIn <= nar[0];
      repeat (4) @(posedge mclk);
      foreach (rt[i]) begin
        e = expCount(rt[i], nar[0]);
        sendRes(rt[i], 1'b1);
        chk("dispCount", e, dispCount);
        chk("count3", expCount(rt[i], nar[0], 1'b0), dispCount3);
        chk("showOver", e == SHOW_OVER, showOver);
        chk("showUnder", e == SHOW_UNDER, showUnder);
      end
    end
    ahbXfer(REG_COUNT, 1'b0, 32'h0, d);
    chk("countReg", 32'hffffffff, d);
    spanNarrowIn <= 1'b0;
    $display("test scale done");
  endtask

  task automatic t_peak();
    peakTrackIn <= 1'b1;
    repeat (4) @(posedge mclk);
    sendRes(24'sh080000, 1'b1);
    chk("peakFirst", 1280, dispCount);
    sendRes(24'sh000800, 1'b1);
    chk("peakKeep", 1280, dispCount);
    sendRes(24'sh100000, 1'b1);
    chk("peakRise", 2560, dispCount);
    peakTrackIn <= 1'b0;
    repeat (4) @(posedge mclk);
    sendRes(24'sh000800, 1'b1);
    chk("peakOff", 5, dispCount);
    ahbXfer(REG_PEAK, 1'b0, 32'h0, d);
    chk("peakCleared", 0, d);
    $display("test peak done");
  endtask

  task automatic t_hold();
    freezeIn <= 1'b1;
    repeat (4) @(posedge mclk);
    held = dispCount;
    c0   = changes;
    sendRes(24'sh080000, 1'b1);
    repeat (2) @(posedge mclk);
    chk("holdCount", held, dispCount);
    chk("holdChanges", c0, changes);
    waitCal(1'b1, n);
    chk("holdCal", 1, n >= 20 && n <= 40);
    freezeIn <= 1'b0;
    waitCal(1'b0, n);
    sendRes(24'sh080000, 1'b1);
    chk("afterHold", 1280, dispCount);
    $display("test hold done");
  endtask

  task automatic t_regs();
    refSel <= 1'b0;
    ahbXfer(REG_IRQSTAT, 1'b1, 32'hf, d);
    ahbXfer(REG_IRQMASK, 1'b1, 32'h1, d);
    repeat (3) @(posedge mclk);
    chk("useExtRef", 1, useExtRef);
    chk("irqIdle", 0, irq);
    sendRes(24'sh000800, 1'b1);
    repeat (2) @(posedge mclk);
    chk("irqSet", 1, irq);
    ahbXfer(REG_IRQSTAT, 1'b1, 32'h1, d);
    repeat (2) @(posedge mclk);
    chk("irqClear", 0, irq);
    ahbXfer(REG_IRQMASK, 1'b1, 32'h0, d);
    sendRes(24'sh000800, 1'b1);
    repeat (2) @(posedge mclk);
    chk("irqMasked", 0, irq);
    ahbXfer(REG_IRQSTAT, 1'b0, 32'h0, d);
    chk("irqPending", 32'h1, d);
    ahbXfer(8'h40, 1'b0, 32'h0, d);
    chk("unmapped", 0, d);
    refSel <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("reference_source_select", 0, useExtRef);
    ahbXfer(REG_CTRL, 1'b1, 32'h1, d);
    waitCal(1'b1, n);
    chk("regCal", 1, n >= 1 && n <= 3);
    waitCal(1'b0, n);
    chk("regCalLength", 1, n >= 29 && n <= 31);
    $display("test regs done");
  endtask

  initial begin
    {hsel, hwrite, freezeIn, peakTrackIn, spanNarrowIn, refStable, resultValid} = '0;
    {errorCnt, nChecks, cycles, sinceRst} = '0;
    haddr  = '0;
    hwdata = '0;
    htrans = 2'h0;
    hsize  = 3'h2;
    refSel = 1'b1;
    ratioIn = '0;
    resetn = 1'b0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    t_powerup();
    t_scale();
    t_peak();
    t_hold();
    t_regs();
    stop_test();
  end
endmodule
